/* hdl/bsp_pkg.sv */
/*
 Constants shared by the barricade storage protection block.
 Assumes a processor clock of 25 MHz and 6-bit characters with a separate word-mark bit.
*/
// Operation
// (R1) Basic load puts the A-address character into the barricade bank register.
// (R2) Protected region runs from the selected bank up to top of memory.
// (R3) Multicharacter mode adds a seventh bit from rightmost bit of A-1.
// (R4) Basic load clears the relocation base bank register.
// (R5) Barricade position equals register value times the bank size.
// (R6) Relocating load puts the B-address character into the relocation base register.
// (R7) In standard mode every program address is offset by the relocation base.
// (R8) Protected writes blocked above barricade or below base unless in interrupt mode.
// (R9) Barricade is placed relative to the relocation base.
// (R10) Clock-enabling form relocates, starts the fine clock, enables the privileged variant.
// (R11) Neither instruction changes any word-mark bit.
// (R12) After either: sequence to next, A minus two, B minus two on relocating form.
// (R13) Fifteen extra index registers sit in sixty characters above the barricade.
// (R14) Load-barricade is privileged while protection is active.
// (R15) Store writes the barricade register to A, clearing unused high bits.
// (R16) Multicharacter store puts seventh bit at rightmost of A-1, other bits zero.
// (R17) Relocating store also writes the relocation base to B likewise.
// (R18) Software issues these instructions only from interrupt mode.
// (R19) Forbidden standard-mode writes are suppressed and flagged as a violation.
package bsp_pkg;
   localparam int ADDR_W = 19;
   localparam int BANK_W = 7;
   localparam int CHAR_W = 6;
   localparam int BANK_SHIFT = 12;
   localparam int INDEX_CHARS = 60;
   localparam int INDEX_REGS = 15;
   localparam logic [BANK_W-1:0] BANK_RESET = 7'h00;
   localparam logic [ADDR_W-1:0] ADDR_STEP2 = 19'h00002;
   localparam logic [ADDR_W-1:0] ADDR_STEP1 = 19'h00001;
   typedef enum logic [1:0] {
      BSP_FMT_BASIC,
      BSP_FMT_RELOC,
      BSP_FMT_CLOCK
   } bsp_fmt_e;
   typedef enum logic {
      BSP_OP_LOAD,
      BSP_OP_STORE
   } bsp_op_e;
endpackage

/* hdl/bsp_relocate.sv */
/*
 Address relocation and write guard for standard-mode references.
 Assumes bank registers are stable while a reference is presented.
*/
`timescale 1ns/1ps
module bsp_relocate #(
   parameter int ADDR_W = bsp_pkg::ADDR_W,
   parameter int BANK_W = bsp_pkg::BANK_W
) (
   input wire logic [ADDR_W-1:0] progAddr,
   input wire logic stdMode,
   input wire logic protectOn,
   input wire logic [BANK_W-1:0] barricadeBank,
   input wire logic [BANK_W-1:0] relocationBaseBank,
   output logic [ADDR_W-1:0] physAddr,
   output logic forbidden
);
   logic [ADDR_W-1:0] baseAddr;
   logic [ADDR_W-1:0] barrAddr;
   logic [ADDR_W:0] barrSum;

   // Bank numbers scaled to locations
   assign baseAddr = ADDR_W'({relocationBaseBank, {bsp_pkg::BANK_SHIFT{1'b0}}}); // R5
   assign barrSum = (ADDR_W+1)'({barricadeBank, {bsp_pkg::BANK_SHIFT{1'b0}}}) + {1'b0, baseAddr}; // R9

   // Offset applies only in standard mode
   assign physAddr = stdMode ? progAddr + baseAddr : progAddr; // R7
   assign barrAddr = barrSum[ADDR_W-1:0];

   // Open region is base up to the relocated barricade, rest is protected to top
   assign forbidden = stdMode && protectOn &&
      ((barrSum[ADDR_W] == 1'b0 && physAddr >= barrAddr) || physAddr < baseAddr); // R2 R8 R9
endmodule

/* hdl/bsp_char_pack.sv */
/*
 Packs and unpacks a 7-bit bank value to and from two 6-bit characters.
 Assumes the caller supplies the multicharacter mode flag.
*/
`timescale 1ns/1ps
module bsp_char_pack #(
   parameter int CHAR_W = bsp_pkg::CHAR_W,
   parameter int BANK_W = bsp_pkg::BANK_W
) (
   input wire logic multiChar,
   input wire logic [CHAR_W-1:0] charAt,
   input wire logic [CHAR_W-1:0] charLeft,
   input wire logic [BANK_W-1:0] bankIn,
   output logic [BANK_W-1:0] bankOut,
   output logic [CHAR_W-1:0] storeAt,
   output logic [CHAR_W-1:0] storeLeft
);
   // Seventh bit comes from rightmost bit of left neighbour
   assign bankOut = {multiChar & charLeft[0], charAt}; // R3 R6
   // Store image with unused high bits cleared
   assign storeAt = bankIn[CHAR_W-1:0]; // R15
   assign storeLeft = {{(CHAR_W-1){1'b0}}, bankIn[BANK_W-1]}; // R16
endmodule

/* hdl/bsp_barricade.sv */
/*
 Barricade storage protection and base relocation for the processor.
 Assumes the sequencer presents one load or store barricade request with operand characters
 already fetched, and memory references with the current processing mode, on sys_clk.
*/
`timescale 1ns/1ps
module bsp_barricade #(
   parameter int ADDR_W = bsp_pkg::ADDR_W,
   parameter int CHAR_W = bsp_pkg::CHAR_W,
   parameter int BANK_W = bsp_pkg::BANK_W
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic multiChar,
   input wire logic interruptMode,
   input wire logic protectOn,
   input wire logic instrValid,
   input wire logic instrOp,
   input wire logic [1:0] instrFmt,
   input wire logic [CHAR_W-1:0] variantChar,
   input wire logic [ADDR_W-1:0] aAddr,
   input wire logic [ADDR_W-1:0] bAddr,
   input wire logic [ADDR_W-1:0] nextInstrAddr,
   input wire logic [CHAR_W-1:0] aChar,
   input wire logic [CHAR_W-1:0] aLeftChar,
   input wire logic [CHAR_W-1:0] bChar,
   input wire logic [CHAR_W-1:0] bLeftChar,
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic [ADDR_W-1:0] progAddr,
   output logic [BANK_W-1:0] barricade_bank_q,
   output logic [BANK_W-1:0] relocation_base_bank_q,
   output logic [ADDR_W-1:0] physAddr_q,
   output logic memReqOut_q,
   output logic memWriteOut_q,
   output logic violation_q,
   output logic privTrap_q,
   output logic storeValid_q,
   output logic storeWordMarkKeep_q,
   output logic [ADDR_W-1:0] storeAddr_q,
   output logic [CHAR_W-1:0] storeChar_q,
   output logic [ADDR_W-1:0] sequence_reg_q,
   output logic [ADDR_W-1:0] a_address_reg_q,
   output logic [ADDR_W-1:0] b_address_reg_q,
   output logic regsValid_q,
   output logic fineClockRun_q,
   output logic [CHAR_W-1:0] privVariantEnable_q,
   output logic [ADDR_W-1:0] extraIndexBase_q,
   output logic [ADDR_W-1:0] extraIndexLimit_q
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ST_ALEFT,
      ST_ST_A,
      ST_ST_BLEFT,
      ST_ST_B
   } bsp_state_e;

   bsp_state_e state_q;
   logic stdMode;
   logic [ADDR_W-1:0] physAddr;
   logic forbidden;
   logic [BANK_W-1:0] aBank;
   logic [BANK_W-1:0] bBank;
   logic [CHAR_W-1:0] aStore;
   logic [CHAR_W-1:0] aStoreLeft;
   logic [CHAR_W-1:0] bStore;
   logic [CHAR_W-1:0] bStoreLeft;
   logic isReloc;
   logic loadReq;
   logic storeReq;
   logic privBlock;
   logic [ADDR_W-1:0] aHeld_q;
   logic [ADDR_W-1:0] bHeld_q;
   logic relocHeld_q;
   logic [ADDR_W-1:0] nxtHeld_q;

   assign stdMode = !interruptMode;
   assign isReloc = instrFmt != 2'(bsp_pkg::BSP_FMT_BASIC);
   // Load refused from standard mode while protection active
   assign privBlock = protectOn && stdMode; // R14
   assign loadReq = instrValid && state_q == ST_IDLE && instrOp == bsp_pkg::BSP_OP_LOAD;
   assign storeReq = instrValid && state_q == ST_IDLE && instrOp == bsp_pkg::BSP_OP_STORE;

   // Relocation and guard
   bsp_relocate #(.ADDR_W(ADDR_W), .BANK_W(BANK_W)) uReloc (
      .progAddr(progAddr),
      .stdMode(stdMode),
      .protectOn(protectOn),
      .barricadeBank(barricade_bank_q),
      .relocationBaseBank(relocation_base_bank_q),
      .physAddr(physAddr),
      .forbidden(forbidden)
   );

   // A operand character pair
   bsp_char_pack #(.CHAR_W(CHAR_W), .BANK_W(BANK_W)) uPackA (
      .multiChar(multiChar),
      .charAt(aChar),
      .charLeft(aLeftChar),
      .bankIn(barricade_bank_q),
      .bankOut(aBank),
      .storeAt(aStore),
      .storeLeft(aStoreLeft)
   );

   // B operand character pair
   bsp_char_pack #(.CHAR_W(CHAR_W), .BANK_W(BANK_W)) uPackB (
      .multiChar(multiChar),
      .charAt(bChar),
      .charLeft(bLeftChar),
      .bankIn(relocation_base_bank_q),
      .bankOut(bBank),
      .storeAt(bStore),
      .storeLeft(bStoreLeft)
   );

   // Bank registers loaded by the load form
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         barricade_bank_q <= bsp_pkg::BANK_RESET;
         relocation_base_bank_q <= bsp_pkg::BANK_RESET;
      end else if (loadReq && !privBlock) begin
         barricade_bank_q <= aBank; // R1 R3
         if (isReloc) begin
            relocation_base_bank_q <= bBank; // R6
         end else begin
            relocation_base_bank_q <= bsp_pkg::BANK_RESET; // R4
         end
      end
   end

   // Privileged-load trap pulse
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         privTrap_q <= 1'b0;
      end else begin
         privTrap_q <= loadReq && privBlock; // R14 R18
      end
   end

   // Clock-enabling form starts fine clock and variant enables
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fineClockRun_q <= 1'b0;
         privVariantEnable_q <= '0;
      end else if (loadReq && !privBlock && instrFmt == 2'(bsp_pkg::BSP_FMT_CLOCK)) begin
         fineClockRun_q <= 1'b1; // R10
         privVariantEnable_q <= variantChar; // R10
      end
   end

   // Extra index register window above the barricade
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         extraIndexBase_q <= '0;
         extraIndexLimit_q <= '0;
      end else begin
         extraIndexBase_q <= ADDR_W'({barricade_bank_q, {bsp_pkg::BANK_SHIFT{1'b0}}}); // R13
         extraIndexLimit_q <= ADDR_W'({barricade_bank_q, {bsp_pkg::BANK_SHIFT{1'b0}}})
            + ADDR_W'(bsp_pkg::INDEX_CHARS - 1); // R13
      end
   end

   // Memory reference path: relocate and suppress forbidden writes
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         physAddr_q <= '0;
         memReqOut_q <= 1'b0;
         memWriteOut_q <= 1'b0;
         violation_q <= 1'b0;
      end else begin
         physAddr_q <= physAddr; // R7
         memReqOut_q <= memReq && !(memWrite && forbidden); // R19
         memWriteOut_q <= memReq && memWrite && !forbidden; // R8
         violation_q <= memReq && memWrite && forbidden; // R19
      end
   end

   // Held operands for the store sequence
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         aHeld_q <= '0;
         bHeld_q <= '0;
         relocHeld_q <= 1'b0;
         nxtHeld_q <= '0;
      end else if (instrValid && state_q == ST_IDLE) begin
         aHeld_q <= aAddr;
         bHeld_q <= bAddr;
         relocHeld_q <= isReloc;
         nxtHeld_q <= nextInstrAddr;
      end
   end

   // Store sequence: B pair first when relocating, then A pair
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (storeReq) begin
                  state_q <= isReloc ? (multiChar ? ST_ST_BLEFT : ST_ST_B)
                     : (multiChar ? ST_ST_ALEFT : ST_ST_A); // R17
               end
            end
            ST_ST_BLEFT: begin
               state_q <= ST_ST_B;
            end
            ST_ST_B: begin
               state_q <= multiChar ? ST_ST_ALEFT : ST_ST_A;
            end
            ST_ST_ALEFT: begin
               state_q <= ST_ST_A;
            end
            ST_ST_A: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Character writes of the store form, word marks left untouched
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         storeValid_q <= 1'b0;
         storeWordMarkKeep_q <= 1'b1;
         storeAddr_q <= '0;
         storeChar_q <= '0;
      end else begin
         storeValid_q <= state_q != ST_IDLE;
         storeWordMarkKeep_q <= 1'b1; // R11
         unique case (state_q)
            ST_ST_BLEFT: begin
               storeAddr_q <= bHeld_q - bsp_pkg::ADDR_STEP1;
               storeChar_q <= bStoreLeft; // R17
            end
            ST_ST_B: begin
               storeAddr_q <= bHeld_q;
               storeChar_q <= bStore; // R17
            end
            ST_ST_ALEFT: begin
               storeAddr_q <= aHeld_q - bsp_pkg::ADDR_STEP1;
               storeChar_q <= aStoreLeft; // R16
            end
            ST_ST_A: begin
               storeAddr_q <= aHeld_q;
               storeChar_q <= aStore; // R15
            end
            ST_IDLE: begin
               storeAddr_q <= storeAddr_q;
               storeChar_q <= storeChar_q;
            end
            default: begin
               storeAddr_q <= storeAddr_q;
               storeChar_q <= storeChar_q;
            end
         endcase
      end
   end

   // Address registers after either instruction
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sequence_reg_q <= '0;
         a_address_reg_q <= '0;
         b_address_reg_q <= '0;
         regsValid_q <= 1'b0;
      end else begin
         regsValid_q <= 1'b0;
         if (loadReq) begin
            sequence_reg_q <= nextInstrAddr; // R12
            a_address_reg_q <= aAddr - bsp_pkg::ADDR_STEP2; // R12
            b_address_reg_q <= isReloc ? bAddr - bsp_pkg::ADDR_STEP2 : bAddr; // R12
            regsValid_q <= 1'b1;
         end else if (state_q == ST_ST_A) begin
            sequence_reg_q <= nxtHeld_q; // R12
            a_address_reg_q <= aHeld_q - bsp_pkg::ADDR_STEP2; // R12
            b_address_reg_q <= relocHeld_q ? bHeld_q - bsp_pkg::ADDR_STEP2 : bHeld_q; // R12
            regsValid_q <= 1'b1;
         end
      end
   end
endmodule

/* tb/bsp_barricade_assertions.sv */
/*
 Port checks for the barricade protection block.
 Bound into every bsp_barricade; one clock, reset active low.
*/
`timescale 1ns/1ps
module bsp_barricade_assertions (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic multiChar,
   input wire logic interruptMode,
   input wire logic protectOn,
   input wire logic instrValid,
   input wire logic instrOp,
   input wire logic [1:0] instrFmt,
   input wire logic [18:0] aAddr,
   input wire logic [5:0] aChar,
   input wire logic [5:0] aLeftChar,
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic [18:0] progAddr,
   input wire logic [6:0] barricade_bank_q,
   input wire logic [6:0] relocation_base_bank_q,
   input wire logic [18:0] physAddr_q,
   input wire logic memWriteOut_q,
   input wire logic violation_q,
   input wire logic privTrap_q,
   input wire logic storeValid_q,
   input wire logic [18:0] storeAddr_q,
   input wire logic [5:0] storeChar_q,
   input wire logic [18:0] a_address_reg_q,
   input wire logic regsValid_q
);
   logic ldOk;
   logic [19:0] relSum;
   logic [19:0] relTop;
   // Accepted load and relocated limits
   assign ldOk = instrValid && !instrOp && !(protectOn && !interruptMode);
   assign relSum = {1'b0, progAddr} + {1'b0, relocation_base_bank_q, 12'h000};
   assign relTop = {1'b0, relocation_base_bank_q, 12'h000} + {1'b0, barricade_bank_q, 12'h000};
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   // Basic single-character store steps
   sequence sStoreReq;
      instrValid && instrOp && instrFmt == 2'h0 && !multiChar;
   endsequence
   sequence sStoreA;
      ##2 storeValid_q && storeAddr_q == $past(aAddr, 2) && storeChar_q == $past(barricade_bank_q[5:0], 2);
   endsequence
   // Bank loads, privilege and address registers
   a_load_bank: assert property (ldOk |=> barricade_bank_q == {$past(multiChar && aLeftChar[0]), $past(aChar)})
      else $error("barricade bank load mismatch");
   a_base_clear: assert property (ldOk && instrFmt == 2'h0 |=> relocation_base_bank_q == 7'h00)
      else $error("relocation base not cleared");
   a_trap_refuse: assert property (instrValid && !instrOp && protectOn && !interruptMode
      |=> privTrap_q && $stable(barricade_bank_q))
      else $error("refused load not trapped");
   a_addr_step: assert property (instrValid && !instrOp |=> regsValid_q && a_address_reg_q == $past(aAddr) - 19'h00002)
      else $error("address register step wrong");
   // Memory references
   a_reloc_add: assert property (memReq && !interruptMode
      |=> physAddr_q == $past(progAddr) + {$past(relocation_base_bank_q), 12'h000})
      else $error("relocated address wrong");
   a_intr_exempt: assert property (memReq && memWrite && interruptMode |=> memWriteOut_q && !violation_q)
      else $error("interrupt mode write blocked");
   a_guard_write: assert property (memReq && memWrite && protectOn && !interruptMode
      && !relSum[19] && !relTop[19] && relSum >= relTop |=> violation_q && !memWriteOut_q)
      else $error("write above barricade passed");
   a_store_char: assert property (sStoreReq |-> sStoreA)
      else $error("stored character wrong");
endmodule

bind bsp_barricade bsp_barricade_assertions i_bsp_barricade_assertions (.*);

/* tb/bsp_seq_model.sv */
/*
 Behavioural sequencer memory facing the barricade block.
 Serves operand characters by low address byte; takes store writes on sys_clk.
*/
`timescale 1ns/1ps
module bsp_seq_model (
   input wire logic sys_clk,
   input wire logic [18:0] aAddr,
   input wire logic [18:0] bAddr,
   input wire logic storeValid,
   input wire logic [18:0] storeAddr,
   input wire logic [5:0] storeChar,
   output logic [5:0] aChar,
   output logic [5:0] aLeftChar,
   output logic [5:0] bChar,
   output logic [5:0] bLeftChar
);
   logic [5:0] mem [256];
   // Operand characters at A, A-1, B, B-1
   assign aChar = mem[aAddr[7:0]];
   assign aLeftChar = mem[8'(aAddr[7:0] - 8'h01)];
   assign bChar = mem[bAddr[7:0]];
   assign bLeftChar = mem[8'(bAddr[7:0] - 8'h01)];
   // Data bits only; word marks are kept apart
   always @(posedge sys_clk) begin
      if (storeValid) begin
         mem[storeAddr[7:0]] <= storeChar;
      end
   end
endmodule

/* tb/tb_top.sv */
/*
 Self-checking bench for the barricade block and its memory model.
 Assumes a 25 MHz sys_clk and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
$display("FAIL %s exp %0h got %0h", n, e, a); end end
module tb_top;
   logic sys_clk, rstn, multiChar, interruptMode, protectOn, instrValid, instrOp, memReq, memWrite;
   logic memReqOut_q, memWriteOut_q, violation_q, privTrap_q, storeValid_q, storeWordMarkKeep_q;
   logic regsValid_q, fineClockRun_q;
   logic [1:0] instrFmt;
   logic [5:0] variantChar, aChar, aLeftChar, bChar, bLeftChar, storeChar_q, privVariantEnable_q;
   logic [6:0] barricade_bank_q, relocation_base_bank_q;
   logic [18:0] aAddr, bAddr, nextInstrAddr, progAddr, physAddr_q, storeAddr_q, sequence_reg_q;
   logic [18:0] a_address_reg_q, b_address_reg_q, extraIndexBase_q, extraIndexLimit_q;
   int errors, samples_checked, expBar, expBase;
   bsp_barricade i_bsp_barricade (.*);
   bsp_seq_model i_bsp_seq_model (.sys_clk, .aAddr, .bAddr, .storeValid(storeValid_q), .storeAddr(storeAddr_q),
      .storeChar(storeChar_q), .aChar, .aLeftChar, .bChar, .bLeftChar);
   // Processor clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic results();
      if (errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, well beyond the planned run
   initial begin
      #400000;
      errors++;
      results();
   end
   function automatic logic [11:0] pair(logic [7:0] i);
      return {i_bsp_seq_model.mem[i], i_bsp_seq_model.mem[8'(i - 8'h01)]};
   endfunction
   // Issue one request with fresh addresses
   task automatic issue(input int op, input int fmt, input int mc, input logic [18:0] a);
      @(posedge sys_clk);
      instrValid <= 1'b1;
      instrOp <= 1'(op);
      instrFmt <= 2'(fmt);
      multiChar <= 1'(mc);
      aAddr <= a;
      bAddr <= a ^ 19'h00080;
      nextInstrAddr <= ~a;
      @(posedge sys_clk);
      instrValid <= 1'b0;
   endtask
   // Load, then compare banks, trap and address registers
   task automatic doLoad(input int fmt, input int mc, input int prot, input int intr);
      logic [18:0] a, b;
      int ac, al, bc, bl, rf;
      a = 19'($urandom);
      b = a ^ 19'h00080;
      ac = $urandom_range(63);
      al = $urandom_range(63);
      bc = $urandom_range(63);
      bl = $urandom_range(63);
      rf = prot && !intr;
      i_bsp_seq_model.mem[a[7:0]] = 6'(ac);
      i_bsp_seq_model.mem[8'(a[7:0] - 8'h01)] = 6'(al);
      i_bsp_seq_model.mem[b[7:0]] = 6'(bc);
      i_bsp_seq_model.mem[8'(b[7:0] - 8'h01)] = 6'(bl);
      @(posedge sys_clk);
      protectOn <= 1'(prot);
      interruptMode <= 1'(intr);
      variantChar <= 6'(bl);
      issue(0, fmt, mc, a);
      @(negedge sys_clk);
      if (!rf) begin
         expBar = (mc & al & 1) * 64 + ac;
         expBase = fmt == 0 ? 0 : (mc & bl & 1) * 64 + bc;
      end
      `CHK("barricade", expBar, barricade_bank_q)
      `CHK("base", expBase, relocation_base_bank_q)
      `CHK("trap", rf, privTrap_q)
      `CHK("regs", {1'b1, ~a, 19'(a - 2), fmt == 0 ? b : 19'(b - 2)},
         {regsValid_q, sequence_reg_q, a_address_reg_q, b_address_reg_q})
      if (fmt == 2 && !rf) `CHK("clock", {1'b1, 6'(bl)}, {fineClockRun_q, privVariantEnable_q})
      @(negedge sys_clk);
      `CHK("index base", expBar * 4096, extraIndexBase_q)
      `CHK("index top", expBar * 4096 + 59, extraIndexLimit_q)
   endtask
   // Store, count character writes, read memory back
   task automatic doStore(input int fmt, input int mc);
      logic [18:0] a, b;
      int n, r;
      a = 19'($urandom);
      b = a ^ 19'h00080;
      n = 0;
      r = 0;
      for (int k = 0; k < 4; k++) i_bsp_seq_model.mem[8'((k[1] ? b[7:0] : a[7:0]) - k[0])] = 6'h3f;
      @(posedge sys_clk);
      interruptMode <= 1'b1;
      issue(1, fmt, mc, a);
      repeat (8) begin
         @(negedge sys_clk);
         n += storeValid_q;
         r += regsValid_q;
         if (storeValid_q === 1'b1) `CHK("word mark", 1'b1, storeWordMarkKeep_q)
         if (regsValid_q === 1'b1) `CHK("store regs", {~a, 19'(a - 2), fmt == 0 ? b : 19'(b - 2)},
            {sequence_reg_q, a_address_reg_q, b_address_reg_q})
      end
      `CHK("writes", (1 + mc) * (1 + fmt), n)
      `CHK("store regs count", 1, r)
      `CHK("at A", {6'(expBar), mc ? 6'(expBar / 64) : 6'h3f}, pair(a[7:0]))
      `CHK("at B", {fmt ? 6'(expBase) : 6'h3f, fmt && mc ? 6'(expBase / 64) : 6'h3f}, pair(b[7:0]))
   endtask
   // Back-to-back random references against the bank model
   task automatic memRound();
      logic [18:0] p;
      int ph, lim, fb, we, it, e;
      int q[$];
      for (int i = 0; i <= 200; i++) begin
         @(posedge sys_clk);
         p = 19'($urandom);
         we = $urandom_range(1);
         it = $urandom_range(3) == 0;
         fb = $urandom_range(3) != 0;
         memReq <= i < 200;
         memWrite <= 1'(we);
         progAddr <= p;
         interruptMode <= 1'(it);
         protectOn <= 1'(fb);
         ph = (p + (it ? 0 : expBase * 4096)) % 524288;
         lim = (expBase + expBar) * 4096;
         fb = !it && fb && we && ((lim < 524288 && ph >= lim) || ph < expBase * 4096);
         q.push_back(ph * 8 + (1 - fb) * 4 + (we && !fb) * 2 + fb);
         @(negedge sys_clk);
         if (i > 0) begin
            e = q.pop_front();
            `CHK("reference", e, {physAddr_q, memReqOut_q, memWriteOut_q, violation_q})
         end
      end
   endtask
   // Reset, every load form, basic and relocating store forms, then reference streams
   initial begin
      {rstn, multiChar, interruptMode, protectOn, instrValid, instrOp, memReq, memWrite} = '0;
      {instrFmt, variantChar, aAddr, bAddr, nextInstrAddr, progAddr} = '0;
      errors = 0;
      samples_checked = 0;
      expBar = 0;
      expBase = 0;
      void'($urandom(18));
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      @(negedge sys_clk);
      `CHK("reset", 17'h00002, {barricade_bank_q, relocation_base_bank_q, fineClockRun_q, storeWordMarkKeep_q,
         violation_q})
      for (int k = 0; k < 24; k++) begin
         doLoad(k % 3, k / 3 % 2, k / 6 % 2, k / 12);
         doStore(k % 2, k / 3 % 2);
      end
      for (int r = 0; r < 3; r++) begin
         doLoad(1, r % 2, 0, 1);
         memRound();
      end
      results();
   end
endmodule
